//--- hw/cda_datapath.sv
// Purpose: data ALU, bit manipulation unit and bus unit of the core
// Assumes: instr is held valid for exactly the cycle it executes
// Notes:   bus outputs are combinational so bus joins add no delay
`timescale 1ns/1ps
`default_nettype none
module cda_datapath #(
    parameter logic [15:0] INT_TOP = cda_pkg::INT_TOP_DEF
) (
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    input  wire cda_pkg::cda_instr_t instr,
    input  wire logic [15:0]        coreGlobalDataBusIn,
    output logic [15:0]             coreGlobalDataBusOut,
    output logic                    coreGlobalDataBusOe_b,
    input  wire logic [15:0]        peripheralGlobalDataBusIn,
    output logic [15:0]             peripheralGlobalDataBusOut,
    output logic                    peripheralGlobalDataBusOe_b,
    input  wire logic [15:0]        xDataBusTwo,
    output logic [15:0]             xAddressBusOne,
    output logic                    xExtSelOne,
    output logic                    xWriteOne,
    output logic [15:0]             xAddressBusTwo,
    output logic                    xReadTwo,
    output cda_pkg::cda_flags_t     flags
);
    import cda_pkg::*;

    cda_regs_t   regs;
    cda_regs_t   next_regs;
    cda_flags_t  next_flags;
    logic        bmPend;
    logic        next_bmPend;
    logic [15:0] bmData;
    logic [15:0] next_bmData;
    cda_bmt_t    bmTgt;
    cda_bmt_t    next_bmTgt;
    logic [15:0] bmAddr;
    logic [15:0] next_bmAddr;

    // Word limiter: a value using its extension saturates
    function automatic logic [15:0] limit16(input logic [35:0] v);
        if (v[35:31] == {5{v[35]}}) begin
            limit16 = v[31:16];
        end else begin
            limit16 = v[35] ? LIM_NEG : LIM_POS;
        end
    endfunction

    function automatic logic [35:0] limit32(input logic [35:0] v);
        if (v[35:31] == {5{v[35]}}) begin
            limit32 = v;
        end else begin
            limit32 = v[35] ? MAC_NEG : MAC_POS;
        end
    endfunction

    // Fractional words sit in the upper half, integers in the lower
    function automatic logic [35:0] widen(input logic [15:0] w, input logic intMode);
        widen = intMode ? {{20{w[15]}}, w} : {{4{w[15]}}, w, 16'h0000};
    endfunction

    function automatic logic [15:0] readReg(input cda_regs_t r, input cda_reg_t sel);
        unique case (sel)
            RG_X0:   readReg = r.x0;
            RG_Y0:   readReg = r.y0;
            RG_Y1:   readReg = r.y1;
            RG_A0:   readReg = r.a[15:0];
            RG_A1:   readReg = r.a[31:16];
            RG_A2:   readReg = {12'h000, r.a[35:32]};
            RG_B0:   readReg = r.b[15:0];
            RG_B1:   readReg = r.b[31:16];
            RG_B2:   readReg = {12'h000, r.b[35:32]};
            RG_ALIM: readReg = limit16(r.a);
            RG_BLIM: readReg = limit16(r.b);
            default: readReg = 16'h0000;
        endcase
    endfunction

    // Full accumulator moves sign-extend and clear the low word
    function automatic cda_regs_t putReg(input cda_regs_t r, input cda_reg_t sel,
                                         input logic [15:0] w);
        putReg = r;
        unique case (sel)
            RG_X0:   putReg.x0 = w;
            RG_Y0:   putReg.y0 = w;
            RG_Y1:   putReg.y1 = w;
            RG_A0:   putReg.a[15:0] = w;
            RG_A1:   putReg.a[31:16] = w;
            RG_A2:   putReg.a[35:32] = w[3:0];
            RG_B0:   putReg.b[15:0] = w;
            RG_B1:   putReg.b[31:16] = w;
            RG_B2:   putReg.b[35:32] = w[3:0];
            RG_ALIM: putReg.a = widen(w, 1'b0);
            RG_BLIM: putReg.b = widen(w, 1'b0);
            default: putReg = r;
        endcase
    endfunction

    function automatic logic [15:0] pickWord(input cda_regs_t r, input cda_src_t s);
        unique case (s)
            SRC_X0:  pickWord = r.x0;
            SRC_Y0:  pickWord = r.y0;
            SRC_Y1:  pickWord = r.y1;
            SRC_A:   pickWord = limit16(r.a);
            SRC_B:   pickWord = limit16(r.b);
            default: pickWord = 16'h0000;
        endcase
    endfunction

    // Operand decode
    wire logic        v      = instr.valid;
    wire cda_op_t     op     = instr.op;
    wire logic [35:0] accD   = instr.dstB ? regs.b : regs.a;
    wire logic        aIsAcc = (instr.srcA == SRC_A) || (instr.srcA == SRC_B);
    wire logic [15:0] opA16  = pickWord(regs, instr.srcA);
    wire logic [15:0] opB16  = pickWord(regs, instr.srcB);
    wire logic [35:0] accA36 = (instr.srcA == SRC_A) ? regs.a : regs.b;
    wire logic [35:0] opA36  = aIsAcc ? accA36 : widen(opA16, instr.integerMode);

    // Multiplier, single cycle and unpipelined
    logic signed [31:0] prodS;
    logic        [31:0] prodU;
    logic        [35:0] prod36;
    assign prodS  = $signed(opA16) * $signed(opB16);
    assign prodU  = opA16 * opB16;
    assign prod36 = instr.unsignedMul ? {4'h0, prodU}
                  : instr.integerMode ? {{4{prodS[31]}}, prodS}
                  : {{3{prodS[31]}}, prodS, 1'b0};

    // Shared adder; carry in chains multi-precision work
    wire logic        isMac  = (op == OP_MAC) || (op == OP_MACN);
    wire logic        subOp  = (op == OP_MACN) || (op == OP_SUB) || (op == OP_SBC);
    wire logic [35:0] addend = isMac ? prod36 : opA36;
    wire logic [35:0] addIn  = subOp ? ~addend : addend;
    wire logic        cinBit = (op == OP_ADC) ? flags.carry
                             : (op == OP_SBC) ? ~flags.carry
                             : subOp;
    logic [36:0] addRes;
    assign addRes = {1'b0, accD} + {1'b0, addIn} + {36'h0_0000_0000, cinBit};
    wire logic        addCarry = subOp ? ~addRes[36] : addRes[36];
    wire logic [35:0] addSat   = instr.satMac ? limit32(addRes[35:0]) : addRes[35:0];

    // Barrel shifter works on one word, arithmetic right shift
    wire logic [3:0]  bsAmt = opB16[3:0];
    wire logic [15:0] bsL   = opA16 << bsAmt;
    wire logic [15:0] bsR   = 16'($signed(opA16) >>> bsAmt);
    wire logic [15:0] bsRes = (op == OP_LSHL) ? bsL : bsR;

    // Logic unit touches only the middle word of the accumulator
    logic [15:0] lgRes;
    always_comb begin
        unique case (op)
            OP_AND:  lgRes = accD[31:16] & opA16;
            OP_OR:   lgRes = accD[31:16] | opA16;
            OP_EOR:  lgRes = accD[31:16] ^ opA16;
            default: lgRes = ~accD[31:16];
        endcase
    end

    wire logic isLogic  = (op == OP_AND) || (op == OP_OR) || (op == OP_EOR) || (op == OP_NOT);
    wire logic isBarrel = (op == OP_LSHL) || (op == OP_LSHR);
    wire logic isBit    = (op == OP_BSET) || (op == OP_BCLR) || (op == OP_BCHG)
                       || (op == OP_BTST) || (op == OP_BRTST);
    wire logic isAlu    = !isBit && (op != OP_NOP);

    logic [35:0] aluRes;
    logic        aluCarry;
    always_comb begin
        aluRes   = accD;
        aluCarry = flags.carry;
        unique case (op)
            OP_MPY: aluRes = instr.satMac ? limit32(prod36) : prod36;
            OP_MAC, OP_MACN, OP_ADD, OP_SUB, OP_ADC, OP_SBC: begin
                aluRes   = addSat;
                aluCarry = addCarry;
            end
            OP_ASL: begin
                aluRes   = {accD[34:0], 1'b0};
                aluCarry = accD[35];
            end
            OP_ASR: begin
                aluRes   = {accD[35], accD[35:1]};
                aluCarry = accD[0];
            end
            OP_LSHL, OP_LSHR: aluRes = widen(bsRes, 1'b0);
            OP_AND, OP_OR, OP_EOR, OP_NOT: aluRes = {accD[35:32], lgRes, accD[15:0]};
            OP_TFR: aluRes = opA36;
            OP_CLR: aluRes = ACC_RST;
            default: aluRes = accD;
        endcase
    end

    wire logic [15:0] res16  = (isLogic || isBarrel) ? (isLogic ? lgRes : bsRes)
                             : limit16(aluRes);
    wire logic        limHit = isMac && instr.satMac && (addSat != addRes[35:0]);

    // Bit manipulation unit
    wire logic [15:0] bmSrc = (instr.bmTarget == BM_CORE) ? readReg(regs, instr.bmReg)
                            : (instr.bmTarget == BM_XMEM) ? coreGlobalDataBusIn
                            : peripheralGlobalDataBusIn;
    wire logic [15:0] bMask = (op == OP_BRTST) ? (instr.mask & (instr.byteHigh ? MASK_HI : MASK_LO))
                            : instr.mask;
    wire logic        bmHit = (bmSrc & bMask) == bMask;
    wire logic [15:0] bmNew = (op == OP_BSET) ? (bmSrc | bMask)
                            : (op == OP_BCLR) ? (bmSrc & ~bMask)
                            : (bmSrc ^ bMask);
    wire logic        bmWr  = v && ((op == OP_BSET) || (op == OP_BCLR) || (op == OP_BCHG));

    // Bus unit: the word seen by core loads
    wire logic [15:0] loadWord = (instr.route == RT_PERI_CORE) ? peripheralGlobalDataBusIn
                               : (instr.route == RT_XTWO_CORE) ? xDataBusTwo
                               : coreGlobalDataBusIn;
    wire logic [15:0] driveWord = readReg(regs, instr.coreDrive);
    wire logic        d16Mem    = v && isAlu && (instr.dst16 == D16_MEM);
    wire logic        coreDrv   = v && (instr.coreDrive != RG_NONE);

    // Pending write-back wins the bus; controller leaves it free
    always_comb begin
        coreGlobalDataBusOe_b = 1'b0;
        if (bmPend && (bmTgt == BM_XMEM)) begin
            coreGlobalDataBusOut = bmData;
        end else if (d16Mem) begin
            coreGlobalDataBusOut = res16;
        end else if (coreDrv) begin
            coreGlobalDataBusOut = driveWord;
        end else if (v && (instr.route == RT_PERI_CORE)) begin
            coreGlobalDataBusOut = peripheralGlobalDataBusIn;
        end else if (v && (instr.route == RT_XTWO_CORE)) begin
            coreGlobalDataBusOut = xDataBusTwo;
        end else begin
            coreGlobalDataBusOut  = 16'h0000;
            coreGlobalDataBusOe_b = 1'b1;
        end
    end

    always_comb begin
        peripheralGlobalDataBusOe_b = 1'b0;
        if (bmPend && (bmTgt == BM_PERI)) begin
            peripheralGlobalDataBusOut = bmData;
        end else if (v && (instr.route == RT_CORE_PERI)) begin
            peripheralGlobalDataBusOut = coreDrv ? driveWord : coreGlobalDataBusIn;
        end else begin
            peripheralGlobalDataBusOut  = 16'h0000;
            peripheralGlobalDataBusOe_b = 1'b1;
        end
    end

    // Write-back reuses the address of its own bit op, not the current one
    assign xAddressBusOne = (bmPend && (bmTgt == BM_XMEM)) ? bmAddr : instr.addrOne;
    assign xExtSelOne     = xAddressBusOne > INT_TOP;
    assign xWriteOne      = (bmPend && (bmTgt == BM_XMEM)) || d16Mem || (v && instr.memWrite);
    assign xAddressBusTwo = instr.addrTwo;
    assign xReadTwo       = v && instr.dualRead && (instr.addrTwo <= INT_TOP);

    // Up to three words land per cycle; ALU result has last say
    always_comb begin
        next_regs   = regs;
        next_flags  = flags;
        next_bmPend = 1'b0;
        next_bmData = bmData;
        next_bmTgt  = bmTgt;
        next_bmAddr = bmAddr;
        if (v) begin
            next_regs = putReg(next_regs, instr.coreLoad, loadWord);
            if (instr.xTwoLoad) begin
                next_regs.x0 = xDataBusTwo;
            end
            if (isBit) begin
                next_flags.bitTest = bmHit;
            end
            if (bmWr && (instr.bmTarget == BM_CORE)) begin
                next_regs = putReg(next_regs, instr.bmReg, bmNew);
            end else if (bmWr) begin
                next_bmPend = 1'b1;
                next_bmData = bmNew;
                next_bmTgt  = instr.bmTarget;
                next_bmAddr = instr.addrOne;
            end
            if (isAlu) begin
                next_flags.carry   = aluCarry;
                next_flags.limited = limHit;
                unique case (instr.dst16)
                    D16_X0:   next_regs.x0 = res16;
                    D16_Y0:   next_regs.y0 = res16;
                    D16_Y1:   next_regs.y1 = res16;
                    D16_MEM:  next_regs = next_regs;
                    default: begin
                        if (instr.dstB) begin
                            next_regs.b = aluRes;
                        end else begin
                            next_regs.a = aluRes;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            regs   <= '{x0: IN_RST, y0: IN_RST, y1: IN_RST, a: ACC_RST, b: ACC_RST};
            flags  <= '0;
            bmPend <= 1'b0;
            bmData <= 16'h0000;
            bmTgt  <= BM_CORE;
            bmAddr <= 16'h0000;
        end else begin
            regs   <= next_regs;
            flags  <= next_flags;
            bmPend <= next_bmPend;
            bmData <= next_bmData;
            bmTgt  <= next_bmTgt;
            bmAddr <= next_bmAddr;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence macIntoA;
        v && (op == OP_MAC) && !instr.dstB && !instr.satMac && (instr.dst16 == D16_NONE);
    endsequence

    sequence periBitWrite;
        bmWr && (instr.bmTarget == BM_PERI) && (op == OP_BSET);
    endsequence

    AST_MAC_ONE_CYCLE: assert property (macIntoA |=> regs.a == $past(regs.a) + $past(prod36))
        else $error("MAC result not in accumulator after one cycle");
    AST_LIMIT_READ: assert property (coreDrv && (instr.coreDrive == RG_ALIM)
        && (regs.a[35:31] != {5{regs.a[35]}}) && !bmPend && !d16Mem
        |-> coreGlobalDataBusOut == (regs.a[35] ? LIM_NEG : LIM_POS))
        else $error("Oversized accumulator not saturated on read");
    AST_EXT_ZERO: assert property (coreDrv && (instr.coreDrive == RG_B2) && !bmPend && !d16Mem
        |-> coreGlobalDataBusOut[15:4] == 12'h000)
        else $error("Unused extension bits not zero");
    AST_XTWO_LOAD: assert property (v && instr.xTwoLoad && !isAlu
        |=> regs.x0 == $past(xDataBusTwo))
        else $error("Bus two word not loaded into x0");
    AST_ROUTE_PERI: assert property (v && (instr.route == RT_CORE_PERI) && !coreDrv && !bmPend
        |-> !peripheralGlobalDataBusOe_b && (peripheralGlobalDataBusOut == coreGlobalDataBusIn))
        else $error("Bus join added delay or wrong data");
    AST_BYTE_TEST: assert property (v && (op == OP_BRTST) && instr.byteHigh && (instr.mask[15:8] == 8'h00)
        |=> flags.bitTest)
        else $error("Byte test looked outside selected byte");
    AST_BIT_WRITEBACK: assert property (periBitWrite
        |=> !peripheralGlobalDataBusOe_b [*1] ##0
            (peripheralGlobalDataBusOut == ($past(peripheralGlobalDataBusIn) | $past(bMask))))
        else $error("Peripheral bit set not written back next cycle");
    AST_XTWO_INTERNAL: assert property (xReadTwo |-> xAddressBusTwo <= INT_TOP)
        else $error("Bus two addressed outside internal memory");
    AST_LOGIC_16: assert property (v && (op == OP_AND) && !instr.dstB && (instr.dst16 == D16_NONE)
        |=> (regs.a[35:32] == $past(regs.a[35:32])) && (regs.a[15:0] == $past(regs.a[15:0])))
        else $error("Logic op disturbed bits outside its word");
    AST_DUAL_READ: assert property (v && instr.dualRead && instr.xTwoLoad && (instr.coreLoad == RG_Y0)
        && (instr.route == RT_NONE) && !isAlu && !isBit
        |=> (regs.x0 == $past(xDataBusTwo)) && (regs.y0 == $past(coreGlobalDataBusIn)))
        else $error("Dual read did not load both registers");
endmodule
`default_nettype wire

//--- hw/cda_pkg.sv
// Purpose: types and constants of the core data ALU datapath
// Assumes: one instruction per clk_sys cycle from the program controller
// Notes:   two-way buses are split into in, out and active-low enable
// Contract
// - Three input regs, two accumulators, paired extensions
// - Multiply, MAC, add, sub, shift, logic: one cycle
// - Two's-complement fractional/integer, unsigned, multi-precision
// - Operands 16, 32 or 36 bits, regs/accumulators
// - Results to accumulator, or 16-bit to reg/memory
// - Arithmetic 16/36-bit results; logic 16-bit only
// - All regs via core bus; x0 also from bus two
// - Barrel shifter plus accumulator shifter and limiters
// - Bit unit tests/sets/clears/inverts masked bits anywhere
// - Bitfield branch tests one byte only
// - Bus unit joins two buses, no delay
// - Narrow registers read zero in unused bits
// - Single access core bus; dual read adds bus two
// - Other core moves core bus; peripherals peripheral bus
// - Three word transfers per cycle, all move kinds
// - Address bus one any memory; two internal only
package cda_pkg;
    localparam logic [15:0] LIM_POS     = 16'h7FFF;
    localparam logic [15:0] LIM_NEG     = 16'h8000;
    localparam logic [35:0] MAC_POS     = 36'h0_7FFF_FFFF;
    localparam logic [35:0] MAC_NEG     = 36'hF_8000_0000;
    localparam logic [15:0] MASK_LO     = 16'h00FF;
    localparam logic [15:0] MASK_HI     = 16'hFF00;
    localparam logic [15:0] IN_RST      = 16'h0000;
    localparam logic [35:0] ACC_RST     = 36'h0_0000_0000;
    localparam logic [15:0] INT_TOP_DEF = 16'h07FF;

    typedef enum logic [4:0] {
        OP_NOP, OP_MPY, OP_MAC, OP_MACN, OP_ADD, OP_SUB, OP_ADC, OP_SBC,
        OP_ASL, OP_ASR, OP_LSHL, OP_LSHR, OP_AND, OP_OR, OP_EOR, OP_NOT,
        OP_TFR, OP_CLR, OP_BSET, OP_BCLR, OP_BCHG, OP_BTST, OP_BRTST
    } cda_op_t;
    typedef enum logic [2:0] {SRC_X0, SRC_Y0, SRC_Y1, SRC_A, SRC_B} cda_src_t;
    typedef enum logic [3:0] {
        RG_NONE, RG_X0, RG_Y0, RG_Y1, RG_A0, RG_A1, RG_A2,
        RG_B0, RG_B1, RG_B2, RG_ALIM, RG_BLIM
    } cda_reg_t;
    typedef enum logic [2:0] {D16_NONE, D16_X0, D16_Y0, D16_Y1, D16_MEM} cda_dst16_t;
    typedef enum logic [1:0] {RT_NONE, RT_CORE_PERI, RT_PERI_CORE, RT_XTWO_CORE} cda_route_t;
    typedef enum logic [1:0] {BM_CORE, BM_XMEM, BM_PERI} cda_bmt_t;

    typedef struct packed {
        logic       valid;
        cda_op_t    op;
        cda_src_t   srcA;
        cda_src_t   srcB;
        logic       dstB;
        logic       integerMode;
        logic       unsignedMul;
        logic       satMac;
        cda_dst16_t dst16;
        cda_reg_t   coreLoad;
        cda_reg_t   coreDrive;
        logic       xTwoLoad;
        cda_route_t route;
        cda_bmt_t   bmTarget;
        cda_reg_t   bmReg;
        logic [15:0] mask;
        logic       byteHigh;
        logic [15:0] addrOne;
        logic [15:0] addrTwo;
        logic       memWrite;
        logic       dualRead;
    } cda_instr_t;

    typedef struct packed {
        logic [15:0] x0;
        logic [15:0] y0;
        logic [15:0] y1;
        logic [35:0] a;
        logic [35:0] b;
    } cda_regs_t;

    typedef struct packed {
        logic carry;
        logic limited;
        logic bitTest;
    } cda_flags_t;
endpackage

//--- verification/cda_xmem_partner.sv
// Purpose: X memory and peripheral register behind the datapath buses
// Assumes: word index is the low address byte
// Notes:   bus two shows inverted data when not read, so stale values fail
`timescale 1ns/1ps
`default_nettype none
module cda_xmem_partner (
    input  wire logic        clk_sys,
    input  wire logic [15:0] coreOut,
    input  wire logic        coreOe_b,
    output logic [15:0]      coreIn,
    input  wire logic [15:0] periOut,
    input  wire logic        periOe_b,
    output logic [15:0]      periIn,
    input  wire logic [15:0] addrOne,
    input  wire logic        writeOne,
    input  wire logic [15:0] addrTwo,
    input  wire logic        readTwo,
    output logic [15:0]      xTwo
);
    logic [15:0] mem [0:255];
    logic [15:0] periReg;
    initial begin
        for (int k = 0; k < 256; k++) begin
            mem[k] = 16'h0101 * k[15:0];
        end
        periReg = 16'h1203;
    end
    assign coreIn = coreOe_b ? mem[addrOne[7:0]] : coreOut;
    assign periIn = periOe_b ? periReg : periOut;
    assign xTwo   = readTwo ? mem[addrTwo[7:0]] : ~mem[addrTwo[7:0]];
    always @(posedge clk_sys) begin
        if (writeOne) mem[addrOne[7:0]] <= coreOut;
        if (!periOe_b) periReg <= periOut;
    end
endmodule
`default_nettype wire

//--- verification/tb_core_data_alu_datapath.sv
// Purpose: self-checking bench of the core data datapath
// Assumes: instructions issued 1 ns after the rising edge
// Notes:   combinational bus outputs are judged within the issuing cycle
`timescale 1ns/1ps
`default_nettype none
module tb_core_data_alu_datapath;
    import cda_pkg::*;
    logic clk_sys, rst_b, cOe, pOe, xSel, xWr, xRd;
    cda_instr_t instr;
    logic [15:0] cIn, cOut, pIn, pOut, x2, a1, a2;
    cda_flags_t flags;
    int errors, n_compared;
    cda_datapath cda_datapath_inst (.clk_sys(clk_sys), .rst_b(rst_b), .instr(instr),
        .coreGlobalDataBusIn(cIn), .coreGlobalDataBusOut(cOut), .coreGlobalDataBusOe_b(cOe),
        .peripheralGlobalDataBusIn(pIn), .peripheralGlobalDataBusOut(pOut),
        .peripheralGlobalDataBusOe_b(pOe), .xDataBusTwo(x2), .xAddressBusOne(a1),
        .xExtSelOne(xSel), .xWriteOne(xWr), .xAddressBusTwo(a2), .xReadTwo(xRd), .flags(flags));
    cda_xmem_partner cda_xmem_partner_inst (.clk_sys(clk_sys), .coreOut(cOut), .coreOe_b(cOe),
        .coreIn(cIn), .periOut(pOut), .periOe_b(pOe), .periIn(pIn), .addrOne(a1),
        .writeOne(xWr), .addrTwo(a2), .readTwo(xRd), .xTwo(x2));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask
    function automatic cda_instr_t op();
        cda_instr_t t;
        t = '0;
        t.valid = 1'b1;
        return t;
    endfunction
    task automatic issue(input cda_instr_t i);
        @(posedge clk_sys);
        #1 instr = i;
    endtask
    task automatic rd(input cda_reg_t r, input logic [15:0] e);
        cda_instr_t i;
        i = op();
        i.coreDrive = r;
        issue(i);
        #1 chk16(cOut, e);
        chk1(cOe, 1'b0);
    endtask
    task automatic t_dual_load();
        cda_instr_t i;
        i = op();
        i.coreLoad = RG_Y0; i.addrOne = 16'h0040; i.dualRead = 1'b1;
        i.addrTwo = 16'h0041; i.xTwoLoad = 1'b1;
        issue(i);
        #1 chk1(xRd, 1'b1);
        rd(RG_Y0, 16'h4040);
        rd(RG_X0, 16'h4141);
        $display("test dual_load done");
    endtask
    task automatic t_store();
        cda_instr_t i;
        i = op();
        i.coreDrive = RG_X0; i.memWrite = 1'b1; i.addrOne = 16'h0020;
        issue(i);
        #1 chk1(xWr, 1'b1);
        i = op();
        i.coreLoad = RG_Y1; i.addrOne = 16'h0020;
        issue(i);
        rd(RG_Y1, 16'h4141);
        $display("test store done");
    endtask
    task automatic t_mac_sat();
        cda_instr_t i;
        i = op();
        i.op = OP_MAC; i.srcA = SRC_Y0; i.srcB = SRC_Y0;
        issue(i);
        rd(RG_A1, 16'h2040);
        rd(RG_A0, 16'h2000);
        rd(RG_A2, 16'h0000);
        cda_xmem_partner_inst.mem[1] = 16'h0001;
        i = op();
        i.coreLoad = RG_A2; i.addrOne = 16'h0001;
        issue(i);
        rd(RG_A2, 16'h0001);
        rd(RG_ALIM, 16'h7FFF);
        $display("test mac_sat done");
    endtask
    task automatic t_addr();
        cda_instr_t i;
        i = op();
        i.addrOne = 16'h0800; i.addrTwo = 16'h0800; i.dualRead = 1'b1;
        issue(i);
        #1 chk1(xSel, 1'b1);
        chk1(xRd, 1'b0);
        chk16(a1, 16'h0800);
        chk16(a2, 16'h0800);
        i.addrOne = 16'h07FF;
        issue(i);
        #1 chk1(xSel, 1'b0);
        $display("test addr done");
    endtask
    task automatic t_bits();
        cda_instr_t i;
        i = op();
        i.op = OP_BSET; i.bmTarget = BM_PERI; i.mask = 16'h00F0;
        issue(i);
        issue(op());
        #1 chk1(pOe, 1'b0);
        chk16(pOut, 16'h12F3);
        issue(op());
        #1 chk1(pOe, 1'b1);
        for (int h = 0; h < 3; h++) begin
            i = op();
            i.op = OP_BRTST; i.bmTarget = BM_CORE; i.bmReg = RG_X0;
            i.mask = (h == 2) ? 16'h0041 : 16'h8041;
            i.byteHigh = (h != 0);
            issue(i);
            issue(op());
            #1 chk1(flags.bitTest, h != 1);
        end
        $display("test bits done");
    endtask
    task automatic t_route();
        cda_instr_t i;
        i = op();
        i.route = RT_CORE_PERI; i.coreDrive = RG_X0;
        issue(i);
        #1 chk16(pOut, 16'h4141);
        chk1(pOe, 1'b0);
        chk16(cOut, 16'h4141);
        i.coreDrive = RG_NONE;
        i.addrOne = 16'h0022;
        issue(i);
        #1 chk16(pOut, 16'h2222);
        $display("test route done");
    endtask
    task automatic t_arith();
        cda_instr_t i;
        i = op();
        i.op = OP_SUB;
        i.srcA = SRC_X0;
        i.dstB = 1'b1;
        i.integerMode = 1'b1;
        issue(i);
        rd(RG_B0, 16'hBEBF);
        chk1(flags.carry, 1'b1);
        rd(RG_B2, 16'h000F);
        i.op = OP_ADC;
        issue(i);
        rd(RG_B0, 16'h0001);
        i = op();
        i.op = OP_AND;
        i.srcA = SRC_X0;
        issue(i);
        rd(RG_A1, 16'h0040);
        i.op = OP_MPY;
        i.srcA = SRC_Y0;
        i.srcB = SRC_Y0;
        i.dst16 = D16_MEM;
        i.addrOne = 16'h0030;
        issue(i);
        #1 chk16(cOut, 16'h2040);
        chk1(xWr, 1'b1);
        rd(RG_A1, 16'h0040);
        i.op = OP_MAC;
        i.dst16 = D16_NONE;
        i.satMac = 1'b1;
        issue(i);
        rd(RG_A1, 16'h7FFF);
        chk1(flags.limited, 1'b1);
        i = op();
        i.op = OP_BCLR;
        i.bmTarget = BM_XMEM;
        i.addrOne = 16'h0030;
        i.mask = 16'h0040;
        issue(i);
        issue(op());
        #1 chk16(a1, 16'h0030);
        chk16(cOut, 16'h2000);
        i = op();
        i.coreLoad = RG_Y1;
        i.addrOne = 16'h0030;
        issue(i);
        rd(RG_Y1, 16'h2000);
        $display("test arith done");
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        errors = 0;
        n_compared = 0;
        instr = '0;
        rst_b = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        t_dual_load();
        t_store();
        t_mac_sat();
        t_addr();
        t_bits();
        t_route();
        t_arith();
        issue('0);
        final_report();
    end
    initial begin
        #20000;
        errors++;
        final_report();
    end
endmodule
`default_nettype wire
